// >>> rtl/umd_consts.vh
// Constants for the unsigned multiply/divide unit
`ifndef UMD_CONSTS_VH
`define UMD_CONSTS_VH

// Operation codes
`define UMD_OP_W          3
`define UMD_OP_DIV        3'h0
`define UMD_OP_DIV_CC     3'h1
`define UMD_OP_MUL        3'h2
`define UMD_OP_MUL_CC     3'h3
`define UMD_OP_MULHI      3'h4

// Instruction field positions
`define UMD_RSV_HI        12
`define UMD_RSV_LO        5
`define UMD_IMM_MSB       12

// Saturated quotient value
`define UMD_DIV_SAT       64'h0000_0000_FFFF_FFFF

// Condition-code layout {n,z,v,c}
`define UMD_CC_N          3
`define UMD_CC_Z          2
`define UMD_CC_V          1
`define UMD_CC_C          0

// Reset values
`define UMD_HIGH_RESET    32'h0000_0000
`define UMD_CC_RESET      4'h0

// Timing counts
`define UMD_DIV_CYCLES    32
`define UMD_MUL_CYCLES    1

`endif

// >>> rtl/umd_divider.v
// Restoring serial 64-by-32 unsigned divider
`timescale 1ns/1ps
`default_nettype none

module umd_divider #(
    parameter integer WIDTH = 32
) (
    input  wire                 clock_i,
    input  wire                 nrst_i,
    input  wire                 start_i,
    input  wire [2*WIDTH-1:0]   dividend_i,
    input  wire [WIDTH-1:0]     divisor_i,
    output reg                  done_o,
    output reg  [WIDTH-1:0]     quotient_o
);

    localparam integer CW = $clog2(WIDTH + 1);

    reg [WIDTH:0]     rem_r;
    reg [WIDTH-1:0]   quo_r;
    reg [WIDTH-1:0]   dsr_r;
    reg [CW-1:0]      cnt_r;
    reg               busy_r;

    wire [WIDTH:0]    shifted = {rem_r[WIDTH-1:0], quo_r[WIDTH-1]};
    wire [WIDTH:0]    diff    = shifted - {1'b0, dsr_r};
    wire              fits    = ~diff[WIDTH] | rem_r[WIDTH-1];

    // Caller guarantees high half < divisor, so remainder never exceeds WIDTH+1 bits
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rem_r      <= {(WIDTH+1){1'b0}};
            quo_r      <= {WIDTH{1'b0}};
            dsr_r      <= {WIDTH{1'b0}};
            cnt_r      <= {CW{1'b0}};
            busy_r     <= 1'b0;
            done_o     <= 1'b0;
            quotient_o <= {WIDTH{1'b0}};
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_r) begin
                rem_r  <= {1'b0, dividend_i[2*WIDTH-1:WIDTH]};
                quo_r  <= dividend_i[WIDTH-1:0];
                dsr_r  <= divisor_i;
                cnt_r  <= WIDTH[CW-1:0];
                busy_r <= 1'b1;
            end else if (busy_r) begin
                // Bits below the quotient fall off: truncation toward zero
                rem_r <= fits ? (shifted - {1'b0, dsr_r}) : shifted;
                quo_r <= {quo_r[WIDTH-2:0], fits};
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
                    busy_r     <= 1'b0;
                    done_o     <= 1'b1;
                    quotient_o <= {quo_r[WIDTH-2:0], fits};
                end
            end
        end
    end

endmodule // umd_divider

`default_nettype wire

// >>> rtl/umd_unit.v
// Unsigned multiply, divide and multiply-high execution unit
//
// Behaviour
// - Dividend is high word over first source
// - High word undefined after any divide
// - Inexact quotient truncates toward zero
// - Quotient overflow saturates to 0000_0000_FFFF_FFFF
// - Normal quotient is zero-extended to 64
// - Plain divide leaves flags untouched
// - Divide flags follow saturated destination value
// - Register-form divide, bits 12:5 set: illegal
// - Word multiply of low 32-bit operands
// - Full product out, upper word to high
// - Flag multiply updates both flag sets
// - Word flags from low product word
// - Register-form multiply, bits 12:5 set: illegal
// - Multiply-high gives upper 64 of 128
// - Multiply-high: no flags, no exceptions
//
// Latency, counted in rising edges from the one that takes issue_i
// to the one that first samples done_o high:
//   Word multiply, illegal form, zero divisor, divide overflow  1
//   Multiply-high                                               2
//   Divide through the serial divider                          35
// The divider adds a start register, 32 steps and a result register.
// Only an idle unit takes issue_i; an issue during a divide is lost,
// so the pipeline waits for done_o before the next one.
`timescale 1ns/1ps
`default_nettype none

`include "umd_consts.vh"

module umd_unit #(
    parameter integer DIV_CYCLES = `UMD_DIV_CYCLES
) (
    input  wire                   clock_i,
    input  wire                   nrst_i,
    input  wire                   issue_i,
    input  wire [`UMD_OP_W-1:0]   op_i,
    input  wire                   use_imm_i,
    input  wire [12:0]            signed_immediate_13_i,
    input  wire [12:5]            rsv_bits_i,
    input  wire [63:0]            first_source_i,
    input  wire [63:0]            second_source_i,
    input  wire                   high_wr_i,
    input  wire [31:0]            high_wr_data_i,
    output reg                    busy_o,
    output reg                    done_o,
    output reg                    rd_we_o,
    output reg  [63:0]            rd_data_o,
    output reg                    icc_we_o,
    output reg  [3:0]             icc_o,
    output reg                    xcc_we_o,
    output reg  [3:0]             xcc_o,
    output reg                    exc_illegal_o,
    output reg                    exc_div_zero_o,
    output reg  [31:0]            high_word_o
);

    //--------------------------------------------------------------
    // States
    //--------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DIV  = 2'h1;
    localparam [1:0] ST_MHI  = 2'h2;

    reg  [1:0]   state_r;
    reg  [1:0]   state_nxt;
    reg  [2:0]   op_r;
    reg  [31:0]  high_r;
    reg  [63:0]  src1_r;
    reg  [63:0]  src2_r;
    reg          div_start_r;

    //--------------------------------------------------------------
    // Operand selection
    //--------------------------------------------------------------
    wire [63:0]  imm_ext  = {{51{signed_immediate_13_i[`UMD_IMM_MSB]}}, signed_immediate_13_i};
    wire [63:0]  src2_sel = use_imm_i ? imm_ext : second_source_i;

    wire is_div   = (op_i == `UMD_OP_DIV) || (op_i == `UMD_OP_DIV_CC);
    wire is_mul   = (op_i == `UMD_OP_MUL) || (op_i == `UMD_OP_MUL_CC);
    wire is_mulhi = (op_i == `UMD_OP_MULHI);
    wire rsv_bad  = !use_imm_i && (rsv_bits_i != 8'h00);

    // Word multiply is single cycle; product of low words
    wire [63:0]  mul_prod = {32'h0000_0000, first_source_i[31:0]}
                          * {32'h0000_0000, src2_sel[31:0]};

    // Zero flags of both widths
    wire mul_z32 = (mul_prod[31:0] == 32'h0000_0000);
    wire mul_z64 = (mul_prod == 64'h0000_0000_0000_0000);

    //--------------------------------------------------------------
    // High word as an issuing divide sees it
    //--------------------------------------------------------------
    // A write in the issue cycle lands first, so the overflow test
    // and the serial divide work on the same dividend
    // A write while busy is dropped
    wire         high_wr_ok   = high_wr_i && (state_r == ST_IDLE);
    wire [31:0]  high_eff     = high_wr_ok ? high_wr_data_i : high_r;

    // Divide overflow: high word >= divisor means quotient >= 2^32
    wire [63:0]  div_dividend = {high_r, src1_r[31:0]};
    wire         div_zero     = (src2_sel[31:0] == 32'h0000_0000);
    wire         div_ovf      = (high_eff >= src2_sel[31:0]);

    //--------------------------------------------------------------
    // Issue decode, in priority order
    //--------------------------------------------------------------
    // Illegal form beats zero divisor, which beats overflow
    // Codes 5 to 7 decode to nothing and raise no done pulse
    wire         take_op  = issue_i && (state_r == ST_IDLE);
    wire         go_ill   = take_op && (is_div || is_mul) && rsv_bad;
    wire         go_dz    = take_op && is_div && !rsv_bad && div_zero;
    wire         go_sat   = take_op && is_div && !rsv_bad && !div_zero && div_ovf;
    wire         go_div   = take_op && is_div && !rsv_bad && !div_zero && !div_ovf;
    wire         go_mul   = take_op && is_mul && !rsv_bad;
    // Multiply-high has no immediate form and never traps
    wire         go_mhi   = take_op && is_mulhi;

    //--------------------------------------------------------------
    // Serial divider
    //--------------------------------------------------------------
    wire         div_done;
    wire [31:0]  div_quo;

    umd_divider #(
        .WIDTH      (32)
    ) u_div (
        .clock_i    (clock_i),
        .nrst_i     (nrst_i),
        .start_i    (div_start_r),
        .dividend_i (div_dividend),
        .divisor_i  (src2_r[31:0]),
        .done_o     (div_done),
        .quotient_o (div_quo)
    );

    //--------------------------------------------------------------
    // Multiply-high: one extra cycle, full product formed from registered operands
    //--------------------------------------------------------------
    wire [127:0] mhi_prod = {64'h0000_0000_0000_0000, src1_r}
                          * {64'h0000_0000_0000_0000, src2_r};

    wire [63:0]  div_res = {32'h0000_0000, div_quo};

    //--------------------------------------------------------------
    // Flag values, layout {n,z,v,c}
    //--------------------------------------------------------------
    // V and c are written clear on every flag update
    localparam [63:0] SAT_VAL = `UMD_DIV_SAT;
    wire         quo_z    = (div_quo == 32'h0000_0000);
    // Saturated flags come from the written value, not the quotient
    wire [3:0]   cc_sat_w = {SAT_VAL[31], (SAT_VAL[31:0] == 32'h0000_0000), 2'b00};
    wire [3:0]   cc_sat_x = {SAT_VAL[63], (SAT_VAL == 64'h0000_0000_0000_0000), 2'b00};
    wire [3:0]   cc_quo_w = {div_quo[31], quo_z, 2'b00};
    wire [3:0]   cc_quo_x = {1'b0, quo_z, 2'b00};
    // Word flags ignore the upper product word
    wire [3:0]   cc_mul_w = {mul_prod[31], mul_z32, 2'b00};
    wire [3:0]   cc_mul_x = {mul_prod[63], mul_z64, 2'b00};

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (go_div) begin
                    state_nxt = ST_DIV;
                end else if (go_mhi) begin
                    state_nxt = ST_MHI;
                end
            end
            ST_DIV: begin
                if (div_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_MHI: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    //--------------------------------------------------------------
    // Sequencing and result registers
    //--------------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r        <= ST_IDLE;
            op_r           <= `UMD_OP_DIV;
            high_r         <= `UMD_HIGH_RESET;
            src1_r         <= 64'h0000_0000_0000_0000;
            src2_r         <= 64'h0000_0000_0000_0000;
            div_start_r    <= 1'b0;
            busy_o         <= 1'b0;
            done_o         <= 1'b0;
            rd_we_o        <= 1'b0;
            rd_data_o      <= 64'h0000_0000_0000_0000;
            icc_we_o       <= 1'b0;
            icc_o          <= `UMD_CC_RESET;
            xcc_we_o       <= 1'b0;
            xcc_o          <= `UMD_CC_RESET;
            exc_illegal_o  <= 1'b0;
            exc_div_zero_o <= 1'b0;
            high_word_o    <= `UMD_HIGH_RESET;
        end else begin
            state_r        <= state_nxt;
            div_start_r    <= 1'b0;
            done_o         <= 1'b0;
            rd_we_o        <= 1'b0;
            icc_we_o       <= 1'b0;
            xcc_we_o       <= 1'b0;
            exc_illegal_o  <= 1'b0;
            exc_div_zero_o <= 1'b0;
            high_word_o    <= high_r;
            // Software write of high word; unit's own writes take priority below
            if (high_wr_ok) begin
                high_r      <= high_wr_data_i;
                high_word_o <= high_wr_data_i;
            end
            case (state_r)
                ST_IDLE: begin
                    if (issue_i) begin
                        op_r   <= op_i;
                        src1_r <= first_source_i;
                        // Multiply-high always takes the second register
                        src2_r <= is_mulhi ? second_source_i : src2_sel;
                        if (go_ill) begin
                            exc_illegal_o <= 1'b1;
                            done_o        <= 1'b1;
                        end else if (go_dz) begin
                            exc_div_zero_o <= 1'b1;
                            done_o         <= 1'b1;
                        end else if (go_sat) begin
                            rd_data_o <= `UMD_DIV_SAT;
                            rd_we_o   <= 1'b1;
                            done_o    <= 1'b1;
                            // High word left as is; its value is not promised
                            if (op_i == `UMD_OP_DIV_CC) begin
                                // Flags from the saturated value
                                icc_we_o <= 1'b1;
                                xcc_we_o <= 1'b1;
                                icc_o    <= cc_sat_w;
                                xcc_o    <= cc_sat_x;
                            end
                        end else if (go_div) begin
                            div_start_r <= 1'b1;
                            busy_o      <= 1'b1;
                        end else if (go_mul) begin
                            rd_data_o   <= mul_prod;
                            rd_we_o     <= 1'b1;
                            high_r      <= mul_prod[63:32];
                            high_word_o <= mul_prod[63:32];
                            done_o      <= 1'b1;
                            if (op_i == `UMD_OP_MUL_CC) begin
                                icc_we_o <= 1'b1;
                                xcc_we_o <= 1'b1;
                                icc_o    <= cc_mul_w;
                                xcc_o    <= cc_mul_x;
                            end
                        end else if (go_mhi) begin
                            busy_o <= 1'b1;
                        end
                    end
                end
                ST_DIV: begin
                    if (div_done) begin
                        busy_o    <= 1'b0;
                        done_o    <= 1'b1;
                        rd_we_o   <= 1'b1;
                        rd_data_o <= div_res;
                        // Dividend high word is not preserved by contract
                        high_r    <= high_r;
                        if (op_r == `UMD_OP_DIV_CC) begin
                            icc_we_o <= 1'b1;
                            xcc_we_o <= 1'b1;
                            icc_o    <= cc_quo_w;
                            xcc_o    <= cc_quo_x;
                        end
                    end
                end
                ST_MHI: begin
                    busy_o    <= 1'b0;
                    done_o    <= 1'b1;
                    rd_we_o   <= 1'b1;
                    // No flag or exception outputs touched here
                    rd_data_o <= mhi_prod[127:64];
                end
                default: begin
                    busy_o <= 1'b0;
                end
            endcase
        end
    end

endmodule // umd_unit

`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the unsigned multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
`include "umd_consts.vh"
module testbench;
    logic        clock_i, nrst_i, high_wr_i, hv;
    logic [31:0] high_wr_data_i, hw;
    logic [63:0] rd, ra, rb;
    logic [3:0]  fi, fx;
    logic [2:0]  c;
    int          err_total, checks, seed, k;
    wire         issue_i, use_imm_i, busy_o, done_o, rd_we_o, icc_we_o, xcc_we_o, exc_illegal_o, exc_div_zero_o;
    wire [2:0]   op_i;
    wire [12:0]  si;
    wire [7:0]   rsv;
    wire [63:0]  a, b, rd_data_o;
    wire [3:0]   icc_o, xcc_o;
    wire [31:0]  high_word_o;
    umd_pipe_model i_umd_pipe_model (.clock_i(clock_i), .done_i(done_o), .issue_o(issue_i), .op_o(op_i),
        .use_imm_o(use_imm_i), .imm_o(si), .rsv_o(rsv), .a_o(a), .b_o(b));
    umd_unit i_umd_unit (.clock_i(clock_i), .nrst_i(nrst_i), .issue_i(issue_i), .op_i(op_i), .use_imm_i(use_imm_i),
        .signed_immediate_13_i(si), .rsv_bits_i(rsv), .first_source_i(a), .second_source_i(b),
        .high_wr_i(high_wr_i), .high_wr_data_i(high_wr_data_i), .busy_o(busy_o), .done_o(done_o),
        .rd_we_o(rd_we_o), .rd_data_o(rd_data_o), .icc_we_o(icc_we_o), .icc_o(icc_o), .xcc_we_o(xcc_we_o),
        .xcc_o(xcc_o), .exc_illegal_o(exc_illegal_o), .exc_div_zero_o(exc_div_zero_o), .high_word_o(high_word_o));
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    task automatic chk(input logic [63:0] s, input logic [63:0] x);
        checks++;
        if (s !== x) begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, s, x);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic setw(input logic [31:0] h);
        @(negedge clock_i);
        {high_wr_i, high_wr_data_i} = {1'b1, h};
        @(negedge clock_i);
        {high_wr_i, high_wr_data_i} = {1'b0, ~h};
        @(negedge clock_i);
        {hw, hv} = {h, 1'b1};
        chk(high_word_o, h);
    endtask
    // ---------------------------------------------
    // Reference model: one operation, then compare
    // ---------------------------------------------
    task automatic op(input logic [2:0] c, input logic im, input logic [12:0] si, input logic [7:0] rv,
                      input logic [63:0] a, input logic [63:0] b);
        logic [63:0]  d, e;
        logic [127:0] w;
        logic         ok, ill, dz, cc;
        d = im ? {{51{si[12]}}, si} : b;
        w = {64'h0, a} * {64'h0, b};
        ill = !im && rv != 8'h00 && c != `UMD_OP_MULHI;
        dz = !ill && c <= `UMD_OP_DIV_CC && d[31:0] == 32'h0;
        cc = !ill && !dz && (c == `UMD_OP_DIV_CC || c == `UMD_OP_MUL_CC);
        if (c == `UMD_OP_MULHI) e = w[127:64];
        else if (c >= `UMD_OP_MUL) e = {32'h0, a[31:0]} * {32'h0, d[31:0]};
        else if (hw >= d[31:0]) e = `UMD_DIV_SAT;
        else e = {hw, a[31:0]} / {32'h0, d[31:0]};
        i_umd_pipe_model.run(c, im, si, rv, a, b, 2'($unsigned($random(seed)) % 3), ok);
        if (!ok) begin
            chk(1'b0, 1'b1);
            summarize();
        end
        chk({exc_illegal_o, exc_div_zero_o, rd_we_o}, {ill, dz, !(ill || dz)});
        if (!(ill || dz)) rd = e;
        chk(rd_data_o, rd);
        if (cc) fi = {rd[31], rd[31:0] == 32'h0, 2'b00};
        if (cc) fx = {rd[63], rd == 64'h0, 2'b00};
        chk({icc_we_o, xcc_we_o, icc_o, xcc_o}, {cc, cc, fi, fx});
        // High word is left unspecified after any divide
        if (c <= `UMD_OP_DIV_CC) hv = 1'b0;
        else if (c != `UMD_OP_MULHI && !ill) {hw, hv} = {e[63:32], 1'b1};
        if (hv) @(negedge clock_i);
        if (hv) chk(high_word_o, hw);
    endtask
    initial begin
        {nrst_i, high_wr_i, high_wr_data_i, rd, fi, fx, hw, hv} = '0;
        seed = 96460;
        err_total = 0;
        checks = 0;
        repeat (8) @(negedge clock_i);
        nrst_i = 1'b1;
        chk({busy_o, done_o, icc_o, xcc_o, high_word_o}, 64'h0);
        $display("reset test done");
        for (k = 0; k < 5; k++) op(3'(k), 1'b0, 13'h0, 8'h81, 64'h1234_5678_9ABC_DEF0, 64'h3);
        $display("illegal test done");
        setw(32'h1234);
        op(`UMD_OP_DIV_CC, 1'b0, 13'h0, 8'h00, 64'h5, 64'h1234);
        setw(32'h1233);
        op(`UMD_OP_DIV_CC, 1'b0, 13'h0, 8'h00, 64'hFFFF_FFFF, 64'hABCD_0000_0000_1234);
        op(`UMD_OP_DIV, 1'b1, 13'h0, 8'h3C, 64'h5, 64'h9);
        setw(32'h0);
        op(`UMD_OP_DIV, 1'b1, 13'h1FFF, 8'h00, 64'h7, 64'h0);
        $display("divide test done");
        op(`UMD_OP_MUL_CC, 1'b0, 13'h0, 8'h00, 64'hFFFF_0001_0001_0000, 64'h1_0000);
        op(`UMD_OP_MUL, 1'b1, 13'h1000, 8'h00, 64'hFFFF_FFFF, 64'h0);
        $display("multiply test done");
        for (k = 0; k < 40; k++) begin
            c = 3'($unsigned($random(seed)) % 5);
            ra = {$random(seed), $random(seed)};
            rb = {$random(seed), $random(seed)};
            if (c <= `UMD_OP_DIV_CC) setw(k[0] ? 32'($random(seed)) & 32'hFF : 32'($random(seed)));
            op(c, 1'($random(seed)), 13'($random(seed)), 8'h00, ra, rb);
        end
        $display("random test done");
        summarize();
    end
endmodule // testbench
`default_nettype wire

// >>> verification/umd_pipe_model.sv
// Pipeline model that issues one operation and holds its operands
`timescale 1ns/1ps
`default_nettype none
module umd_pipe_model (
    input  wire logic        clock_i,
    input  wire logic        done_i,
    output var  logic        issue_o,
    output var  logic [2:0]  op_o,
    output var  logic        use_imm_o,
    output var  logic [12:0] imm_o,
    output var  logic [7:0]  rsv_o,
    output var  logic [63:0] a_o,
    output var  logic [63:0] b_o
);
    initial {issue_o, op_o, use_imm_o, imm_o, rsv_o, a_o, b_o} = '0;
    task automatic run(input logic [2:0] c, input logic im, input logic [12:0] si, input logic [7:0] rv,
                       input logic [63:0] a, input logic [63:0] b, input logic [1:0] slow, output logic ok);
        int n;
        repeat (slow + 1) @(negedge clock_i);
        {issue_o, op_o, use_imm_o, imm_o, rsv_o, a_o, b_o} = {1'b1, c, im, si, rv, a, b};
        ok = 1'b0;
        for (n = 0; n < 60 && !ok; n++) begin
            @(negedge clock_i);
            issue_o = 1'b0;
            ok = done_i;
        end
        // Stale operands must not pass for valid ones
        {a_o, b_o} = ~{a_o, b_o};
    endtask
endmodule // umd_pipe_model
`default_nettype wire

// >>> verification/umd_unit_sva.sv
// Port checker for the unsigned multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
`include "umd_consts.vh"
module umd_unit_chk #(
    parameter integer DIV_CYCLES = `UMD_DIV_CYCLES
) (
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        issue_i,
    input wire logic [2:0]  op_i,
    input wire logic        use_imm_i,
    input wire logic [12:0] signed_immediate_13_i,
    input wire logic [12:5] rsv_bits_i,
    input wire logic [63:0] first_source_i,
    input wire logic [63:0] second_source_i,
    input wire logic        high_wr_i,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic        rd_we_o,
    input wire logic [63:0] rd_data_o,
    input wire logic        icc_we_o,
    input wire logic [3:0]  icc_o,
    input wire logic        xcc_we_o,
    input wire logic [3:0]  xcc_o,
    input wire logic        exc_illegal_o,
    input wire logic        exc_div_zero_o,
    input wire logic [31:0] high_word_o
);
    localparam int DLAT = DIV_CYCLES + 3;
    wire [63:0]  op2 = use_imm_i ? {{51{signed_immediate_13_i[12]}}, signed_immediate_13_i} : second_source_i;
    wire [31:0]  dv = op2[31:0];
    wire [63:0]  prod = {32'h0, first_source_i[31:0]} * {32'h0, dv};
    wire [127:0] wide = {64'h0, first_source_i} * {64'h0, second_source_i};
    wire [63:0]  quo = {high_word_o, first_source_i[31:0]} / {32'h0, dv};
    wire         take = issue_i && !busy_o && !done_o;
    wire         bad = !use_imm_i && rsv_bits_i != 8'h00;
    wire         isd = op_i == `UMD_OP_DIV || op_i == `UMD_OP_DIV_CC;
    wire         ism = op_i == `UMD_OP_MUL || op_i == `UMD_OP_MUL_CC;
    // High word seen at the port lags a write by one cycle
    wire         dok = take && isd && !bad && !high_wr_i;
    reg  [2:0]   op_r;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i)
            op_r <= 3'h0;
        else if (take)
            op_r <= op_i;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    mul_result_a: assert property (take && ism && !bad |=> done_o && rd_we_o && rd_data_o == $past(prod))
        else $error("word product wrong");
    mul_high_a: assert property (take && ism && !bad |-> ##2 high_word_o == rd_data_o[63:32])
        else $error("high word not product top");
    illegal_a: assert property (take && (isd || ism) && bad |=> done_o && exc_illegal_o && !rd_we_o)
        else $error("illegal form executed");
    div_zero_a: assert property (dok && dv == 32'h0 |=> done_o && exc_div_zero_o && !rd_we_o)
        else $error("zero divisor not trapped");
    div_sat_a: assert property (dok && !$past(high_wr_i) && dv != 32'h0 && high_word_o >= dv |=> rd_data_o == `UMD_DIV_SAT)
        else $error("overflow not saturated");
    div_quot_a: assert property (dok && !$past(high_wr_i) && high_word_o < dv |-> ##DLAT done_o && rd_data_o == $past(quo, DLAT))
        else $error("quotient wrong");
    cc_value_a: assert property (icc_we_o |-> icc_o[`UMD_CC_N] == rd_data_o[31] && icc_o[`UMD_CC_Z] == (rd_data_o[31:0] == 32'h0))
        else $error("word flags wrong");
    xcc_value_a: assert property (xcc_we_o |-> xcc_o[`UMD_CC_N] == rd_data_o[63] && xcc_o[`UMD_CC_Z] == (rd_data_o == 64'h0) && xcc_o[1:0] == 2'b00)
        else $error("wide flags wrong");
    plain_cc_a: assert property (done_o && op_r != `UMD_OP_DIV_CC && op_r != `UMD_OP_MUL_CC |-> !icc_we_o && !xcc_we_o)
        else $error("flags written by plain op");
    cc_both_a: assert property (done_o && op_r == `UMD_OP_MUL_CC && !exc_illegal_o |-> icc_we_o && xcc_we_o)
        else $error("flag sets not both written");
    mulhi_a: assert property (take && op_i == `UMD_OP_MULHI |-> ##2 done_o && rd_data_o == $past(wide[127:64], 2) && !exc_illegal_o)
        else $error("high product wrong");
    cover property (dok && high_word_o < dv);
    cover property (icc_we_o && rd_data_o[31:0] == 32'h0);
    cover property (exc_illegal_o);
    cover property (take && op_i == `UMD_OP_MULHI && use_imm_i);
endmodule // umd_unit_chk
bind umd_unit umd_unit_chk #(.DIV_CYCLES(DIV_CYCLES)) i_umd_unit_chk (.*);
`default_nettype wire
